// ---- rtl/lsm_pkg.sv ----
package lsm_pkg;
  localparam int CH_NUM = 4;
  localparam int CLK_HZ = 100_000_000;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MASK = 8'h11;
  localparam logic [7:0] IDX_EDGE = 8'h13;
  localparam logic [7:0] IDX_LINE_STATUS_ZERO = 8'h14;
  localparam logic [7:0] IDX_LINE_STATUS_ONE = 8'h15;
  localparam logic [7:0] IDX_ISTS = 8'h16;
  localparam logic [7:0] IDX_CTRL = 8'h17;
  // status and control bit positions
  localparam int B_EQ = 7;
  localparam int B_UP = 6;
  localparam int B_DOWN = 5;
  localparam int B_PAT = 4;
  localparam int B_TCLK = 3;
  localparam int B_DF = 2;
  localparam int B_AIS = 1;
  localparam int B_LOS = 0;
  localparam int B_RLP = 5;
  localparam int B_AUTO_REMOTE_LOOP_ENABLE = 0;
  // reset values
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_STAT = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // bits that follow their input directly
  localparam logic [7:0] LEVEL_BITS = 8'h97;
  // timing
  localparam int QUAL_SHORT_MS = 40;
  localparam int QUAL_LONG_MS = 5100;
  localparam int QUAL_SHORT_CYC = QUAL_SHORT_MS * (CLK_HZ / 1000);
  localparam int QUAL_LONG_CYC = QUAL_LONG_MS * (CLK_HZ / 1000);
  localparam logic [7:0] TCLK_LOSS_CYC = 8'h46;
  // error rate window: under 10 errors in 1000 bits
  localparam logic [9:0] BER_WIN_BITS = 10'h3e8;
  localparam logic [9:0] BER_ERR_LIM = 10'h00a;
endpackage

// ---- rtl/lsm_top.sv ----
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
// Function
// - status bit 7 is one while the equalizer is out of range
// - bit 6 sets after the activate code is held longer than t
// - bit 6 stays set through bit errors while error rate under 1e-2
// - t is 40 ms without auto remote loop, 5.1 s with it
// - rising edge of bit 6 closes the remote loopback
// - bit 5 sets after the deactivate code is held longer than t
// - bit 5 stays set through bit errors while error rate under 1e-2
// - rising edge of bit 5 opens the remote loopback unless bit 6 rises in the same cycle
// - bit 4 shows test pattern lock in real time
// - bit 3 sets when tx clock has not toggled for over 70 cycles
// - bit 2 is one while a driver short circuit is detected
// - bit 1 is one while alarm indication signal is detected
// - bit 0 is one while loss of signal is detected
// - unmasked bit with edge select zero gives event on rise only
// - unmasked bit with edge select one gives event on any change
// - two read-only line status registers per channel, reset to zero
// - mask bits reset to one; zero enables the source
// - events latch in interrupt status, cleared by a read
module lsm_top #(
  parameter int unsigned QUAL_SHORT_CYC = lsm_pkg::QUAL_SHORT_CYC,
  parameter int unsigned QUAL_LONG_CYC = lsm_pkg::QUAL_LONG_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // wishbone slave
  input wire logic [11:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic wb_we_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  // line conditions, one bit per channel
  input wire logic [3:0] eq_out_range_in,
  input wire logic [3:0] loop_up_match_in,
  input wire logic [3:0] loop_down_match_in,
  input wire logic [3:0] pattern_detect_in,
  input wire logic [3:0] channel_tx_clock_in,
  input wire logic [3:0] driver_short_in,
  input wire logic [3:0] ais_detect_in,
  input wire logic [3:0] signal_loss_in,
  // received code bit strobe, same clock
  input wire logic [3:0] code_bit_strobe_in,
  // outputs
  output logic [3:0] remote_loop_out,
  output logic irq_out
);
  logic [7:0] sync1_reg [4];
  logic [7:0] sync2_reg [4];
  logic [7:0] lvl_reg [4];
  logic [7:0] prev_reg [4];
  logic [7:0] stat_w [4];
  logic [7:0] mask_reg [4];
  logic [7:0] edge_reg [4];
  logic [7:0] ists_reg [4];
  logic [3:0] auto_remote_loop_enable_reg;
  logic [3:0] rlp_reg;
  logic [3:0] tclk_d_reg;
  logic [3:0] tclk_loss_reg;
  logic [7:0] idle_cnt_reg [4];
  logic [1:0] code_flag_reg [4];
  logic [31:0] qual_cnt_reg [4][2];
  logic [9:0] bit_cnt_reg [4][2];
  logic [9:0] err_cnt_reg [4][2];
  logic [3:0] rd_clr;
  logic [3:0] irq_ch;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic acc;
  logic [9:0] idx;
  logic [1:0] ch;
  logic [7:0] reg_idx;
  logic [1:0] run_cnt_reg;

  assign acc = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign idx = wb_adr_in[11:2];
  assign ch = idx[7:6];
  assign reg_idx = {2'b00, idx[5:0]};
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdat_reg;
  assign remote_loop_out = rlp_reg;
  assign irq_out = |irq_ch;

  genvar c, k;
  for (c = 0; c < lsm_pkg::CH_NUM; c++) begin : g_ch
    logic [7:0] raw;
    assign raw = {eq_out_range_in[c], loop_up_match_in[c],
      loop_down_match_in[c], pattern_detect_in[c],
      channel_tx_clock_in[c], driver_short_in[c],
      ais_detect_in[c], signal_loss_in[c]};
    assign stat_w[c] = (lvl_reg[c] & lsm_pkg::LEVEL_BITS) |
      {1'b0, code_flag_reg[c], 1'b0, tclk_loss_reg[c], 3'b000};
    assign rd_clr[c] = acc & ~wb_we_in & (idx[9:8] == 2'b00) &
      (ch == 2'(c)) & (reg_idx == lsm_pkg::IDX_ISTS);
    assign irq_ch[c] = |(ists_reg[c] & ~mask_reg[c]);

    // input synchroniser
    always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
        sync1_reg[c] <= lsm_pkg::RST_STAT;
        sync2_reg[c] <= lsm_pkg::RST_STAT;
      end else begin
        sync1_reg[c] <= raw;
        sync2_reg[c] <= sync1_reg[c];
      end
    end

    // real-time level bits
    always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
        lvl_reg[c] <= lsm_pkg::RST_STAT;
      end else begin
        lvl_reg[c] <= sync2_reg[c];
      end
    end

    // tx clock activity
    always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
        tclk_d_reg[c] <= 1'b0;
        idle_cnt_reg[c] <= 8'h00;
        tclk_loss_reg[c] <= 1'b0;
      end else begin
        tclk_d_reg[c] <= sync2_reg[c][lsm_pkg::B_TCLK];
        if (tclk_d_reg[c] != sync2_reg[c][lsm_pkg::B_TCLK]) begin
          idle_cnt_reg[c] <= 8'h00;
          tclk_loss_reg[c] <= 1'b0;
        end else if (idle_cnt_reg[c] <= lsm_pkg::TCLK_LOSS_CYC) begin
          idle_cnt_reg[c] <= idle_cnt_reg[c] + 8'h01;
        end else begin
          tclk_loss_reg[c] <= 1'b1;
        end
      end
    end

    // inband loop code qualification, k=0 activate, k=1 deactivate
    for (k = 0; k < 2; k++) begin : g_code
      logic match;
      logic [31:0] lim;
      logic [9:0] err_next;
      assign match = sync2_reg[c][lsm_pkg::B_UP - k];
      assign lim = auto_remote_loop_enable_reg[c] ? QUAL_LONG_CYC : QUAL_SHORT_CYC;
      assign err_next = err_cnt_reg[c][k] + {9'h000, ~match};
      always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
          code_flag_reg[c][1-k] <= 1'b0;
          qual_cnt_reg[c][k] <= 32'h0000_0000;
          bit_cnt_reg[c][k] <= 10'h000;
          err_cnt_reg[c][k] <= 10'h000;
        end else if (!code_flag_reg[c][1-k]) begin
          bit_cnt_reg[c][k] <= 10'h000;
          err_cnt_reg[c][k] <= 10'h000;
          if (!match) begin
            qual_cnt_reg[c][k] <= 32'h0000_0000;
          end else if (qual_cnt_reg[c][k] >= lim) begin
            code_flag_reg[c][1-k] <= 1'b1;
            qual_cnt_reg[c][k] <= 32'h0000_0000;
          end else begin
            qual_cnt_reg[c][k] <= qual_cnt_reg[c][k] + 32'h0000_0001;
          end
        end else if (code_bit_strobe_in[c]) begin
          if (bit_cnt_reg[c][k] == lsm_pkg::BER_WIN_BITS - 10'h001) begin
            bit_cnt_reg[c][k] <= 10'h000;
            err_cnt_reg[c][k] <= 10'h000;
            if (err_next >= lsm_pkg::BER_ERR_LIM) begin
              code_flag_reg[c][1-k] <= 1'b0;
            end
          end else begin
            bit_cnt_reg[c][k] <= bit_cnt_reg[c][k] + 10'h001;
            err_cnt_reg[c][k] <= err_next;
          end
        end
      end
    end

    // remote loopback switching
    always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
        rlp_reg[c] <= 1'b0;
      end else if (stat_w[c][lsm_pkg::B_UP] &
          ~prev_reg[c][lsm_pkg::B_UP]) begin
        rlp_reg[c] <= 1'b1;
      end else if (stat_w[c][lsm_pkg::B_DOWN] &
          ~prev_reg[c][lsm_pkg::B_DOWN]) begin
        rlp_reg[c] <= 1'b0;
      end
    end

    // change detection and sticky interrupt status
    always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
        prev_reg[c] <= lsm_pkg::RST_STAT;
        ists_reg[c] <= lsm_pkg::RST_STAT;
      end else begin
        prev_reg[c] <= stat_w[c];
        ists_reg[c] <= (ists_reg[c] & ~{8{rd_clr[c]}}) |
          (stat_w[c] & ~prev_reg[c]) |
          (edge_reg[c] & (stat_w[c] ^ prev_reg[c]));
      end
    end
  end

  // wishbone acknowledge and run-time counter
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ack_reg <= 1'b0;
      run_cnt_reg <= 2'b00;
    end else begin
      ack_reg <= acc;
      if (run_cnt_reg != 2'b11) begin
        run_cnt_reg <= run_cnt_reg + 2'b01;
      end
    end
  end

  // register writes
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < lsm_pkg::CH_NUM; i++) begin
        mask_reg[i] <= lsm_pkg::RST_MASK;
        edge_reg[i] <= lsm_pkg::RST_EDGE;
      end
      auto_remote_loop_enable_reg <= 4'h0;
    end else if (acc & wb_we_in & wb_sel_in[0] & (idx[9:8] == 2'b00)) begin
      if (reg_idx == lsm_pkg::IDX_MASK) begin
        mask_reg[ch] <= wb_dat_in[7:0];
      end else if (reg_idx == lsm_pkg::IDX_EDGE) begin
        edge_reg[ch] <= wb_dat_in[7:0];
      end else if (reg_idx == lsm_pkg::IDX_CTRL) begin
        auto_remote_loop_enable_reg[ch] <= wb_dat_in[lsm_pkg::B_AUTO_REMOTE_LOOP_ENABLE];
      end
    end
  end

  // register reads
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rdat_reg <= 32'h0000_0000;
    end else if (acc) begin
      rdat_reg <= 32'h0000_0000;
      if (wb_we_in || idx[9:8] != 2'b00) begin
        rdat_reg <= 32'h0000_0000;
      end else if (reg_idx == lsm_pkg::IDX_MASK) begin
        rdat_reg[7:0] <= mask_reg[ch];
      end else if (reg_idx == lsm_pkg::IDX_EDGE) begin
        rdat_reg[7:0] <= edge_reg[ch];
      end else if (reg_idx == lsm_pkg::IDX_LINE_STATUS_ZERO) begin
        rdat_reg[7:0] <= stat_w[ch];
      end else if (reg_idx == lsm_pkg::IDX_LINE_STATUS_ONE) begin
        rdat_reg[lsm_pkg::B_RLP] <= rlp_reg[ch];
      end else if (reg_idx == lsm_pkg::IDX_ISTS) begin
        rdat_reg[7:0] <= ists_reg[ch];
      end else if (reg_idx == lsm_pkg::IDX_CTRL) begin
        rdat_reg[lsm_pkg::B_AUTO_REMOTE_LOOP_ENABLE] <= auto_remote_loop_enable_reg[ch];
      end
    end
  end

  // checks on the channels the tests exercise
  // independent idle count of the synced tx clock on channel 2
  logic [7:0] tclk_idle_chk_reg;
  logic tclk_sync_chk_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      tclk_idle_chk_reg <= 8'h00;
      tclk_sync_chk_reg <= 1'b0;
    end else begin
      tclk_sync_chk_reg <= sync2_reg[2][lsm_pkg::B_TCLK];
      if (tclk_sync_chk_reg != sync2_reg[2][lsm_pkg::B_TCLK]) begin
        tclk_idle_chk_reg <= 8'h00;
      end else if (tclk_idle_chk_reg != 8'hff) begin
        tclk_idle_chk_reg <= tclk_idle_chk_reg + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  eq_track_a: assert property ((run_cnt_reg == 2'b11) |->
    stat_w[0][7] == $past(eq_out_range_in[0], 3))
    else $error("equalizer bit does not follow input");
  los_track_a: assert property ((run_cnt_reg == 2'b11) |->
    stat_w[0][0] == $past(signal_loss_in[0], 3))
    else $error("signal loss bit does not follow input");
  pat_track_a: assert property ((run_cnt_reg == 2'b11) |->
    stat_w[1][4] == $past(pattern_detect_in[1], 3))
    else $error("pattern lock bit does not follow input");
  drv_track_a: assert property ((run_cnt_reg == 2'b11) |->
    stat_w[2][2] == $past(driver_short_in[2], 3))
    else $error("driver fault bit does not follow input");
  ais_track_a: assert property ((run_cnt_reg == 2'b11) |->
    stat_w[3][1] == $past(ais_detect_in[3], 3))
    else $error("alarm indication bit does not follow input");
  stat_zero_a: assert property ((run_cnt_reg != 2'b11) |->
    stat_w[0] == 8'h00)
    else $error("status not zero after reset");
  up_qualify_a: assert property ($rose(code_flag_reg[1][1]) |->
    $past(g_ch[1].g_code[0].match) &&
    $past(qual_cnt_reg[1][0]) >= $past(g_ch[1].g_code[0].lim))
    else $error("activate flag set before qualification");
  down_qualify_a: assert property ($rose(code_flag_reg[1][0]) |->
    $past(qual_cnt_reg[1][1]) >= $past(g_ch[1].g_code[1].lim))
    else $error("deactivate flag set before qualification");
  loop_hold_a: assert property ((code_flag_reg[1][1] &&
    !code_bit_strobe_in[1]) |=> code_flag_reg[1][1])
    else $error("activate flag dropped between bits");
  down_hold_a: assert property ((code_flag_reg[1][0] &&
    !code_bit_strobe_in[1]) |=> code_flag_reg[1][0])
    else $error("deactivate flag dropped between bits");
  qual_time_a: assert property (!auto_remote_loop_enable_reg[1] |->
    g_ch[1].g_code[0].lim == QUAL_SHORT_CYC)
    else $error("wrong qualification time");
  qual_long_a: assert property (auto_remote_loop_enable_reg[3] |->
    g_ch[3].g_code[0].lim == QUAL_LONG_CYC)
    else $error("wrong long qualification time");
  loop_on_a: assert property ($rose(stat_w[1][6]) |=>
    remote_loop_out[1])
    else $error("remote loop not closed");
  loop_off_a: assert property (($rose(stat_w[1][5]) &&
    !$rose(stat_w[1][6])) |=> !remote_loop_out[1])
    else $error("remote loop not opened");
  loop_steady_a: assert property ((!$rose(stat_w[1][6]) &&
    !$rose(stat_w[1][5])) |=>
    $stable(remote_loop_out[1]))
    else $error("remote loop changed without a code edge");
  tclk_loss_a: assert property (tclk_loss_reg[2] |->
    tclk_idle_chk_reg > lsm_pkg::TCLK_LOSS_CYC)
    else $error("tx clock loss flagged early");
  tclk_late_a: assert property ((tclk_idle_chk_reg >
    lsm_pkg::TCLK_LOSS_CYC && tclk_sync_chk_reg ==
    sync2_reg[2][lsm_pkg::B_TCLK]) |=> tclk_loss_reg[2])
    else $error("tx clock loss not flagged");
  rise_event_a: assert property ($rose(stat_w[0][0]) |=>
    ists_reg[0][0])
    else $error("rising change not latched");
  fall_event_a: assert property (($fell(stat_w[0][7]) &&
    !edge_reg[0][7] && !ists_reg[0][7] && !rd_clr[0]) |=>
    !ists_reg[0][7])
    else $error("falling change latched with edge select zero");
  any_change_a: assert property ((edge_reg[1][4] &&
    $changed(stat_w[1][4])) |=> ists_reg[1][4])
    else $error("change not latched with edge select one");
  ists_hold_a: assert property ((ists_reg[0][0] &&
    !rd_clr[0]) |=> ists_reg[0][0])
    else $error("interrupt status lost without a read");
  read_clear_a: assert property ((rd_clr[0] &&
    stat_w[0] == prev_reg[0]) |=> ists_reg[0] == 8'h00)
    else $error("interrupt status not cleared by read");
  irq_mask_a: assert property (((ists_reg[0] &
    ~mask_reg[0]) != 8'h00) |-> irq_out)
    else $error("unmasked status gives no interrupt");
  ack_answer_a: assert property ((wb_cyc_in && wb_stb_in &&
    !wb_ack_out) |=> wb_ack_out)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("acknowledge longer than one cycle");
  dat_upper_a: assert property (wb_ack_out |->
    wb_dat_out[31:8] == 24'h00_0000)
    else $error("upper read data not zero");

  up_set_c: cover property ($rose(code_flag_reg[1][1]));
  down_set_c: cover property ($rose(code_flag_reg[1][0]));
  loop_c: cover property ($rose(remote_loop_out[1]));
  tclk_c: cover property ($rose(tclk_loss_reg[2]));
  irq_c: cover property ($rose(irq_out));
endmodule

// ---- dv/lsm_top_tb.sv ----
`timescale 1ns/10ps
module lsm_top_tb;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [3:0] eq = 4'h0, up = 4'h0, dn = 4'h0, pat = 4'h0, tclk = 4'h0;
  logic [3:0] drv = 4'h0, ais = 4'h0, los = 4'h0, strb = 4'h0;
  logic [3:0] trun = 4'hf;
  logic ack, irq;
  logic [31:0] rdat;
  logic [3:0] rloop;
  logic [7:0] rd, m;
  int mismatches = 0, checks = 0, cyc_n = 0, n;
  // rows: status bit, channel, edge select
  logic [2:0] rb [5] = '{3'h7, 3'h4, 3'h2, 3'h1, 3'h0};
  logic [1:0] rc [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic re [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  lsm_top #(.QUAL_SHORT_CYC(40), .QUAL_LONG_CYC(200)) lsm_top_inst (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .wb_adr_in(adr),
    .wb_dat_in(wdat), .wb_sel_in(sel), .wb_we_in(we), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_ack_out(ack), .wb_dat_out(rdat),
    .eq_out_range_in(eq), .loop_up_match_in(up), .loop_down_match_in(dn),
    .pattern_detect_in(pat), .channel_tx_clock_in(tclk),
    .driver_short_in(drv), .ais_detect_in(ais), .signal_loss_in(los),
    .code_bit_strobe_in(strb), .remote_loop_out(rloop), .irq_out(irq));

  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) tclk <= tclk ^ trun;
  always @(posedge clk_sys_in) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string s);
    mismatches++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic chk(input logic [7:0] g, e, input string s);
    checks++;
    if (g !== e) fail(s);
  endtask
  function automatic logic [9:0] ix(input logic [1:0] c, input logic [7:0] r);
    return {2'b00, c, r[5:0]};
  endfunction
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge clk_sys_in);
    adr <= {a, 2'b00};
    we <= w;
    wdat <= {24'h00_0000, d};
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (ack !== 1'b1 && k < 16);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 16) fail("no bus ack");
  endtask
  task automatic wr(input logic [1:0] c, input logic [7:0] r, d);
    bus(ix(c, r), 1'b1, d);
  endtask
  task automatic rc_(input logic [1:0] c, input logic [7:0] r, e, string s);
    bus(ix(c, r), 1'b0, 8'h00);
    chk(rd, e, s);
  endtask
  task automatic cond(input logic [2:0] b, input logic [1:0] c, input logic v);
    case (b)
      3'h7: eq[c] <= v;
      3'h4: pat[c] <= v;
      3'h2: drv[c] <= v;
      3'h1: ais[c] <= v;
      default: los[c] <= v;
    endcase
  endtask
  // code bits with the first ne of them in error
  task automatic bits(input int ne);
    for (int i = 0; i < 1020; i++) begin
      @(posedge clk_sys_in);
      strb[1] <= 1'b1;
      up[1] <= (i >= ne);
      @(posedge clk_sys_in);
      strb[1] <= 1'b0;
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rc_(0, lsm_pkg::IDX_MASK, 8'hff, "mask reset");
    rc_(3, lsm_pkg::IDX_EDGE, 8'h00, "edge reset");
    rc_(3, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h00, "status reset");
    wr(0, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'hff);
    rc_(0, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h00, "status written");
    rc_(0, 8'h10, 8'h00, "unmapped read");
    los[3] <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chk({7'h00, irq}, 8'h00, "masked irq");
    rc_(3, lsm_pkg::IDX_ISTS, 8'h01, "event latch");
    los[3] <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rc_(3, lsm_pkg::IDX_ISTS, 8'h00, "fall event");
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      m = 8'h01 << rb[i];
      wr(rc[i], lsm_pkg::IDX_MASK, ~m);
      wr(rc[i], lsm_pkg::IDX_EDGE, re[i] ? m : 8'h00);
      cond(rb[i], rc[i], 1'b1);
      repeat (6) @(posedge clk_sys_in);
      chk({7'h00, irq}, 8'h01, "irq on rise");
      rc_(rc[i], lsm_pkg::IDX_LINE_STATUS_ZERO, m, "level set");
      rc_(rc[i], lsm_pkg::IDX_ISTS, m, "rise event");
      chk({7'h00, irq}, 8'h00, "irq after read");
      cond(rb[i], rc[i], 1'b0);
      repeat (6) @(posedge clk_sys_in);
      rc_(rc[i], lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h00, "level clear");
      chk({7'h00, irq}, {7'h00, re[i]}, "irq on fall");
      rc_(rc[i], lsm_pkg::IDX_ISTS, re[i] ? m : 8'h00, "fall ev");
      wr(rc[i], lsm_pkg::IDX_MASK, 8'hff);
      $display("row %0d done", i);
    end
    wr(2, lsm_pkg::IDX_MASK, 8'hf7);
    trun[2] <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk_sys_in);
      n++;
    end
    checks++;
    if (n < 71 || n > 80) fail("tx clock loss delay");
    rc_(2, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h08, "tx clock loss");
    trun[2] <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rc_(2, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h00, "tx clock back");
    wr(2, lsm_pkg::IDX_MASK, 8'hff);
    $display("tx clock test done");
    up[1] <= 1'b1;
    repeat (30) @(posedge clk_sys_in);
    rc_(1, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h00, "loop up early");
    repeat (30) @(posedge clk_sys_in);
    rc_(1, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h40, "loop up set");
    chk({7'h00, rloop[1]}, 8'h01, "loop closed");
    rc_(1, lsm_pkg::IDX_LINE_STATUS_ONE, 8'h20, "loop status");
    bits(5);
    rc_(1, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h40, "few errors");
    bits(1020);
    rc_(1, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h00, "many errors");
    dn[1] <= 1'b1;
    repeat (60) @(posedge clk_sys_in);
    rc_(1, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h20, "loop down set");
    chk({7'h00, rloop[1]}, 8'h00, "loop opened");
    wr(3, lsm_pkg::IDX_CTRL, 8'h01);
    rc_(3, lsm_pkg::IDX_CTRL, 8'h01, "control");
    up[3] <= 1'b1;
    repeat (100) @(posedge clk_sys_in);
    rc_(3, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h00, "long t early");
    repeat (120) @(posedge clk_sys_in);
    rc_(3, lsm_pkg::IDX_LINE_STATUS_ZERO, 8'h40, "long t set");
    chk({7'h00, rloop[3]}, 8'h01, "long loop");
    $display("loop code test done");
    report_and_stop();
  end
endmodule
